// *** shared/fbp_pkg.sv ***
/*
  Constants and types shared by the flash buffer-program host controller.
  Assumes a 16-bit parallel NOR flash with a 40 MHz controller clock.
*/
`default_nettype none

package fbp_pkg;

  // ==========================================================
  // Clock and bus timing
  localparam int CLK_MHZ  = 40;
  localparam int T_WE_NS  = 45;
  localparam int T_RD_NS  = 90;
  localparam int WE_CYC   = (T_WE_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_CYC   = (T_RD_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Command addresses and codes
  localparam logic [11:0] UL_ADDR1    = 12'h555;
  localparam logic [11:0] UL_ADDR2    = 12'h2aa;
  localparam logic [7:0]  UL_DATA1    = 8'haa;
  localparam logic [7:0]  UL_DATA2    = 8'h55;
  localparam logic [7:0]  CMD_BYPASS  = 8'h20;
  localparam logic [7:0]  CMD_BUFLOAD = 8'h25;
  localparam logic [7:0]  CMD_CONFIRM = 8'h29;
  localparam logic [7:0]  CMD_RESET   = 8'hf0;
  localparam logic [7:0]  CMD_BYP_X1  = 8'h90;
  localparam logic [7:0]  CMD_BYP_X2  = 8'h00;

  // ==========================================================
  // Write buffer and status bit positions
  localparam logic [7:0] BUF_WORDS  = 8'h80;
  localparam int         PAGE_LSB   = 7;
  localparam int         POLL_BIT   = 7;
  localparam int         TOGGLE_BIT = 6;
  localparam int         FAIL_BIT   = 5;
  localparam int         ABORT_BIT  = 1;

  // ==========================================================
  // User operations
  typedef enum logic [2:0] {
    OP_BYP_ENTER,
    OP_BYP_EXIT,
    OP_BUF_PROG,
    OP_RESET,
    OP_ABORT_RESET,
    OP_ACCEL_ON,
    OP_ACCEL_OFF
  } fbp_op_t;

endpackage : fbp_pkg

`default_nettype wire

// *** shared/fbp_cyc_if.sv ***
/*
  Carrier between the sequencer and the bus-cycle engine.
  Assumes one request at a time, answered by a one-cycle done.
*/
`timescale 1ns/1ps
`default_nettype none

interface fbp_cyc_if #(parameter int AW = 22);
  logic          req;
  logic          wr;
  logic [AW-1:0] addr;
  logic [15:0]   wdata;
  logic [15:0]   rdata;
  logic          done;

  modport seq (output req, output wr, output addr, output wdata, input rdata, input done);
  modport eng (input req, input wr, input addr, input wdata, output rdata, output done);
endinterface : fbp_cyc_if

`default_nettype wire

// *** rtl/fbp_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two; in_ready_o is registered.
*/
`timescale 1ns/1ps
`default_nettype none

module fbp_fifo #(
  parameter int W     = 23,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // Fill side
  input  wire logic         in_valid_i,
  output var  logic         in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output var  logic         out_valid_o,
  input  wire logic         out_ready_i,
  output var  logic [W-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          push;
  logic          pop;

  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem[rp_r];
  assign cnt_nxt     = cnt_r + CW'(push) - CW'(pop);

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r       <= '0;
      rp_r       <= '0;
      cnt_r      <= '0;
      in_ready_o <= 1'b0;
    end else begin
      wp_r       <= wp_r + PW'(push);
      rp_r       <= rp_r + PW'(pop);
      cnt_r      <= cnt_nxt;
      in_ready_o <= (cnt_nxt != CW'(DEPTH));
    end
  end

  a_fifo_no_over: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cnt_r <= CW'(DEPTH) && (cnt_r != CW'(DEPTH) || !in_ready_o)) else $error("FIFO count beyond depth");

endmodule : fbp_fifo

`default_nettype wire

// *** rtl/fbp_cyc.sv ***
/*
  Bus-cycle engine: one asynchronous flash write or read per request.
  Assumes flash pins are sampled synchronously; all pin outputs are flops.
*/
`timescale 1ns/1ps
`default_nettype none

module fbp_cyc #(
  parameter int AW = 22
) (
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          rst_n_i,
  // Sequencer side
  fbp_cyc_if.eng             cyc,
  // Flash pins
  output var  logic [AW-1:0] flash_addr_o,
  output var  logic [15:0]   flash_dq_o,
  output var  logic          flash_dq_oe_o,
  input  wire logic [15:0]   flash_dq_i,
  output var  logic          flash_ce_n_o,
  output var  logic          flash_we_n_o,
  output var  logic          flash_oe_n_o
);
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fbp_cst_t;

  fbp_cst_t   st_r;
  logic       wr_r;
  logic [3:0] t_r;

  // Strobe length is loaded once so a slow read cannot shorten a write.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r          <= C_IDLE;
      wr_r          <= 1'b0;
      t_r           <= '0;
      flash_addr_o  <= '0;
      flash_dq_o    <= '0;
      flash_dq_oe_o <= 1'b0;
      flash_ce_n_o  <= 1'b1;
      flash_we_n_o  <= 1'b1;
      flash_oe_n_o  <= 1'b1;
      cyc.rdata     <= '0;
      cyc.done      <= 1'b0;
    end else begin
      cyc.done <= 1'b0;
      case (st_r)
        C_IDLE: if (cyc.req) begin
          wr_r          <= cyc.wr;
          flash_addr_o  <= cyc.addr;
          flash_dq_o    <= cyc.wdata;
          flash_dq_oe_o <= cyc.wr;
          flash_ce_n_o  <= 1'b0;
          st_r          <= C_SETUP;
        end
        C_SETUP: begin
          flash_we_n_o <= !wr_r;
          flash_oe_n_o <= wr_r;
          t_r          <= wr_r ? 4'(fbp_pkg::WE_CYC - 1) : 4'(fbp_pkg::RD_CYC - 1);
          st_r         <= C_STROBE;
        end
        C_STROBE: if (t_r == '0) begin
          flash_we_n_o <= 1'b1;
          flash_oe_n_o <= 1'b1;
          if (!wr_r) begin
            cyc.rdata <= flash_dq_i;
          end
          st_r <= C_HOLD;
        end else begin
          t_r <= t_r - 4'h1;
        end
        C_HOLD: begin
          flash_ce_n_o  <= 1'b1;
          flash_dq_oe_o <= 1'b0;
          cyc.done      <= 1'b1;
          st_r          <= C_IDLE;
        end
        default: st_r <= C_IDLE;
      endcase
    end
  end

  a_we_pulse_width: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(flash_we_n_o) |-> !flash_we_n_o [*2] ##1 flash_we_n_o) else $error("Write strobe width wrong");

endmodule : fbp_cyc

`default_nettype wire

// *** rtl/fbp_host.sv ***
/*
  Host controller for a parallel NOR flash: unlock bypass entry and exit,
  write-buffer programming with status polling, resets, accelerate pin.
  Assumes sector unlocking is done elsewhere and reported on sectors_unlocked_i.
*/
// How it works
// - Bypass entry: two unlock writes then code 20h.
// - Bypass exit: write 90h at any address, then 00h.
// - Buffer program: unlocks, load command at sector, then sector and count minus one.
// - After the last load, write the confirm command at the sector address.
// - Abort shows abort flag high; host then issues the abort reset sequence.
// - Poll status at the last loaded address.
// - In accelerated bypass, abort reset uses the full three-cycle sequence.
// - Sectors must be unlocked before raising the accelerate pin.
// - After failure write reset; after abort write the abort reset.
// - After seeing the failure bit, read the polling bit once more.
`timescale 1ns/1ps
`default_nettype none

module fbp_host #(
  parameter int AW         = 22,
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // Command port
  input  wire logic              cmd_valid_i,
  input  wire fbp_pkg::fbp_op_t  cmd_op_i,
  input  wire logic [AW-1:0]     cmd_addr_i,
  input  wire logic [7:0]        cmd_count_i,
  input  wire logic              sectors_unlocked_i,
  output var  logic              cmd_ready_o,
  // Result and mode
  output var  logic              done_o,
  output var  logic              fail_o,
  output var  logic              abort_o,
  output var  logic              refused_o,
  output var  logic              bypass_o,
  output var  logic [7:0]        status_o,
  // Buffer data stream
  input  wire logic              wr_valid_i,
  input  wire logic [6:0]        wr_off_i,
  input  wire logic [15:0]       wr_data_i,
  output var  logic              wr_ready_o,
  // Flash pins
  output var  logic [AW-1:0]     flash_addr_o,
  output var  logic [15:0]       flash_dq_o,
  output var  logic              flash_dq_oe_o,
  input  wire logic [15:0]       flash_dq_i,
  output var  logic              flash_ce_n_o,
  output var  logic              flash_we_n_o,
  output var  logic              flash_oe_n_o,
  output var  logic              flash_accel_hv_o
);

  typedef enum logic [3:0] {
    S_IDLE, S_UL1, S_UL2, S_CODE, S_TAIL, S_CNT, S_LOAD, S_CONF, S_POLL, S_REPOLL
  } fbp_st_t;

  // ==========================================================
  // State
  fbp_st_t          state_r;
  fbp_st_t          state_nxt;
  fbp_pkg::fbp_op_t op_r;
  fbp_pkg::fbp_op_t op_nxt;
  logic             pend_r;
  logic [AW-1:0]    sa_r;
  logic [AW-1:0]    last_addr_r;
  logic             last_d7_r;
  logic [7:0]       cnt_r;
  logic [7:0]       remain_r;
  logic             accel_r;

  fbp_cyc_if #(.AW(AW)) cyc ();

  // ==========================================================
  // Data FIFO
  logic        fq_valid;
  logic        fq_ready;
  logic [22:0] fq_data;

  fbp_fifo #(.W(23), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .in_valid_i (wr_valid_i),
    .in_ready_o (wr_ready_o),
    .in_data_i  ({wr_off_i, wr_data_i}),
    .out_valid_o(fq_valid),
    .out_ready_i(fq_ready),
    .out_data_o (fq_data)
  );

  fbp_cyc #(.AW(AW)) u_cyc (
    .sys_clk_i    (sys_clk_i),
    .rst_n_i      (rst_n_i),
    .cyc          (cyc.eng),
    .flash_addr_o (flash_addr_o),
    .flash_dq_o   (flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o),
    .flash_dq_i   (flash_dq_i),
    .flash_ce_n_o (flash_ce_n_o),
    .flash_we_n_o (flash_we_n_o),
    .flash_oe_n_o (flash_oe_n_o)
  );

  // ==========================================================
  // Command decode and refusal
  logic take;
  logic bad_cmd;
  logic [7:0] code_w;
  logic [AW-1:0] load_addr;
  logic needs_bus;
  logic poll_ok;

  assign take = cmd_valid_i & cmd_ready_o;
  // host never sends an oversize count
  assign bad_cmd = (cmd_op_i == fbp_pkg::OP_BYP_ENTER && bypass_o)
                 | (cmd_op_i == fbp_pkg::OP_BYP_EXIT && (!bypass_o || accel_r))
                 | (cmd_op_i == fbp_pkg::OP_BUF_PROG
                    && (cmd_count_i == 8'h00 || cmd_count_i > fbp_pkg::BUF_WORDS))
                 | (cmd_op_i == fbp_pkg::OP_ACCEL_ON && (!sectors_unlocked_i || accel_r))
                 | (cmd_op_i == fbp_pkg::OP_ACCEL_OFF && !accel_r);

  assign code_w = (op_r == fbp_pkg::OP_BYP_ENTER) ? fbp_pkg::CMD_BYPASS  :
                  (op_r == fbp_pkg::OP_BUF_PROG)  ? fbp_pkg::CMD_BUFLOAD :
                  (op_r == fbp_pkg::OP_BYP_EXIT)  ? fbp_pkg::CMD_BYP_X1  : fbp_pkg::CMD_RESET;

  // the offset only reaches inside the page, so no pair can leave it
  // the page bits come from the sector address, so the sector cannot change
  assign load_addr = {sa_r[AW-1:fbp_pkg::PAGE_LSB], fq_data[22:16]};

  assign needs_bus = (state_r != S_IDLE) && !pend_r && (state_r != S_LOAD || fq_valid);
  assign cyc.req   = needs_bus;
  assign cyc.wr    = (state_r != S_POLL) && (state_r != S_REPOLL);
  assign fq_ready  = needs_bus && state_r == S_LOAD;

  always_comb begin
    cyc.addr  = '0;
    cyc.wdata = '0;
    case (state_r)
      S_UL1: begin
        cyc.addr  = AW'(fbp_pkg::UL_ADDR1);
        cyc.wdata = 16'(fbp_pkg::UL_DATA1);
      end
      S_UL2: begin
        cyc.addr  = AW'(fbp_pkg::UL_ADDR2);
        cyc.wdata = 16'(fbp_pkg::UL_DATA2);
      end
      S_CODE: begin
        cyc.addr  = (op_r == fbp_pkg::OP_BUF_PROG) ? sa_r : AW'(fbp_pkg::UL_ADDR1);
        cyc.wdata = 16'(code_w);
      end
      S_TAIL: cyc.wdata = 16'(fbp_pkg::CMD_BYP_X2);
      S_CNT: begin
        cyc.addr  = sa_r;
        cyc.wdata = 16'(cnt_r - 8'h01);
      end
      S_LOAD: begin
        cyc.addr  = load_addr;
        cyc.wdata = fq_data[15:0];
      end
      S_CONF: begin
        cyc.addr  = sa_r;
        cyc.wdata = 16'(fbp_pkg::CMD_CONFIRM);
      end
      S_POLL, S_REPOLL: cyc.addr = last_addr_r;
      default: cyc.addr = '0;
    endcase
  end

  // ==========================================================
  // Sequencer
  // a polling bit equal to the written bit means the program finished
  assign poll_ok = (cyc.rdata[fbp_pkg::POLL_BIT] == last_d7_r);

  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    case (state_r)
      S_IDLE: if (take && !bad_cmd) begin
        op_nxt = cmd_op_i;
        case (cmd_op_i)
          // abort reset always unlocks in full
          fbp_pkg::OP_BYP_ENTER, fbp_pkg::OP_ABORT_RESET: state_nxt = S_UL1;
          // in bypass the unlock pair is skipped
          fbp_pkg::OP_BUF_PROG: state_nxt = bypass_o ? S_CODE : S_UL1;
          fbp_pkg::OP_RESET, fbp_pkg::OP_BYP_EXIT: state_nxt = S_CODE;
          default: state_nxt = S_IDLE;
        endcase
      end
      S_UL1: if (cyc.done) state_nxt = S_UL2;
      S_UL2: if (cyc.done) state_nxt = S_CODE;
      S_CODE: if (cyc.done) begin
        state_nxt = (op_r == fbp_pkg::OP_BUF_PROG) ? S_CNT :
                    (op_r == fbp_pkg::OP_BYP_EXIT) ? S_TAIL : S_IDLE;
      end
      S_TAIL: if (cyc.done) state_nxt = S_IDLE;
      S_CNT: if (cyc.done) state_nxt = S_LOAD;
      S_LOAD: if (cyc.done && remain_r == 8'h01) state_nxt = S_CONF;
      S_CONF: if (cyc.done) state_nxt = S_POLL;
      S_POLL: if (cyc.done) begin
        if (poll_ok) begin
          state_nxt = S_IDLE;
        // abort flag seen: follow with the abort reset
        end else if (cyc.rdata[fbp_pkg::ABORT_BIT]) begin
          op_nxt    = fbp_pkg::OP_ABORT_RESET;
          state_nxt = S_UL1;
        end else if (cyc.rdata[fbp_pkg::FAIL_BIT]) begin
          state_nxt = S_REPOLL;
        end
      end
      // failure is cleared with the plain reset
      S_REPOLL: if (cyc.done) begin
        if (poll_ok) begin
          state_nxt = S_IDLE;
        end else begin
          op_nxt    = fbp_pkg::OP_RESET;
          state_nxt = S_CODE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  logic idle_take;
  logic poll_done;
  assign idle_take = (state_r == S_IDLE) && take;
  assign poll_done = cyc.done && (state_r == S_POLL || state_r == S_REPOLL);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= S_IDLE;
      op_r    <= fbp_pkg::OP_RESET;
      pend_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      pend_r  <= (pend_r && !cyc.done) || cyc.req;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sa_r        <= '0;
      cnt_r       <= 8'h00;
      remain_r    <= 8'h00;
      last_addr_r <= '0;
      last_d7_r   <= 1'b0;
      status_o    <= 8'h00;
    end else begin
      if (idle_take) begin
        sa_r  <= cmd_addr_i;
        cnt_r <= cmd_count_i;
      end
      if (state_r == S_CNT) begin
        remain_r <= cnt_r;
      end else if (state_r == S_LOAD && cyc.done) begin
        remain_r <= remain_r - 8'h01;
      end
      // the last loaded address is where status is polled
      if (fq_ready) begin
        last_addr_r <= load_addr;
        last_d7_r   <= fq_data[fbp_pkg::POLL_BIT];
      end
      if (poll_done) begin
        status_o <= cyc.rdata[7:0];
      end
    end
  end

  // ==========================================================
  // Mode flags and result pulses
  logic fin_ok;
  assign fin_ok = (state_nxt == S_IDLE) && (state_r != S_IDLE);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accel_r          <= 1'b0;
      flash_accel_hv_o <= 1'b0;
      bypass_o         <= 1'b0;
      cmd_ready_o      <= 1'b0;
      done_o           <= 1'b0;
      fail_o           <= 1'b0;
      abort_o          <= 1'b0;
      refused_o        <= 1'b0;
    end else begin
      cmd_ready_o <= (state_nxt == S_IDLE) && !idle_take;
      refused_o   <= idle_take && bad_cmd;
      done_o      <= fin_ok || (idle_take && !bad_cmd && state_nxt == S_IDLE);
      abort_o     <= poll_done && state_r == S_POLL && !poll_ok && cyc.rdata[fbp_pkg::ABORT_BIT];
      fail_o      <= poll_done && state_r == S_REPOLL && !poll_ok;
      // the pin only rises when sectors are reported unlocked
      // the device enters bypass with the pin, so the mode follows it
      if (idle_take && !bad_cmd && cmd_op_i == fbp_pkg::OP_ACCEL_ON) begin
        accel_r          <= 1'b1;
        flash_accel_hv_o <= 1'b1;
        bypass_o         <= 1'b1;
      end else if (idle_take && !bad_cmd && cmd_op_i == fbp_pkg::OP_ACCEL_OFF) begin
        accel_r          <= 1'b0;
        flash_accel_hv_o <= 1'b0;
        bypass_o         <= 1'b0;
      // bypass is set once the entry code is written
      end else if (state_r == S_CODE && cyc.done && op_r == fbp_pkg::OP_BYP_ENTER) begin
        bypass_o <= 1'b1;
      // bypass ends after the 00h cycle
      end else if (state_r == S_TAIL && cyc.done) begin
        bypass_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  a_bypass_entry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cyc.req && state_r == S_CODE && op_r == fbp_pkg::OP_BYP_ENTER)
    |-> cyc.wdata == 16'h0020 && $past(state_r == S_UL2)) else $error("Bad bypass entry");

  a_bypass_exit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cyc.done && state_r == S_TAIL) |=> !bypass_o && state_r == S_IDLE) else $error("Bypass exit wrong");

  a_count_header: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cyc.req && state_r == S_CNT) |-> cyc.addr == sa_r && cyc.wdata[7:0] == cnt_r - 8'h01)
    else $error("Bad count write");

  a_confirm_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cyc.req && state_r == S_CONF) |-> cyc.wdata == 16'h0029 && cyc.addr == sa_r && remain_r == 8'h00)
    else $error("Bad confirm write");

  a_abort_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    abort_o |-> state_r == S_UL1 && op_r == fbp_pkg::OP_ABORT_RESET) else $error("No abort reset");

  a_poll_address: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cyc.req && state_r == S_POLL) |-> !cyc.wr && cyc.addr == last_addr_r) else $error("Poll address wrong");

  a_full_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cyc.req && state_r == S_CODE && op_r == fbp_pkg::OP_ABORT_RESET)
    |-> cyc.wdata == 16'h00f0 && cyc.addr == AW'(12'h555)) else $error("Abort reset not full");

  a_accel_unlock: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(flash_accel_hv_o) |-> $past(sectors_unlocked_i) && bypass_o) else $error("Accel raised while locked");

  a_fail_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    fail_o |-> state_r == S_CODE && op_r == fbp_pkg::OP_RESET) else $error("No reset after failure");

  a_repoll_first: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    fail_o |-> $past(state_r, 2) == S_REPOLL || $past(state_r) == S_REPOLL) else $error("Fail without re-read");

endmodule : fbp_host

`default_nettype wire

// *** tb/fbp_flash_model.sv ***
/* Behavioural flash for the host bench: command decode, write buffer, status.
   Assumes the host drives whole write cycles with ce_n low. */
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_model #(parameter int AW = 22) (
  // Flash pins
  input  wire logic [AW-1:0] a_i,
  input  wire logic [15:0]   d_i,
  input  wire logic          ce_n_i,
  input  wire logic          we_n_i,
  input  wire logic          oe_n_i,
  input  wire logic          hv_i,
  // Fault orders
  input  wire logic          abt_i,
  input  wire logic          fl_i,
  output logic [15:0]        q_o
);
  logic [15:0] mem [128];
  logic [15:0] ld = '0, q_l = '0;
  logic [7:0]  cnt = '0;
  logic [AW-1:15] sa;
  logic [AW-1:7]  pg;
  logic [1:0] ul = '0, st = '0, bsy = '0;
  logic byp = 0, x1 = 0, fst = 0, ab = 0, fail = 0, tg = 0;
  int nwr = 0;
  wire logic rd = !ce_n_i && !oe_n_i;
  wire logic hold = bsy != 0 || ab || fail;
  assign q_o = rd ? (hold ? {8'h0, ld[7] ^ hold, tg, fail, 3'b0, ab, 1'b0} : mem[a_i[6:0]]) : ~q_l;
  always @(q_o) if (rd) q_l = q_o;
  always @(posedge oe_n_i) begin
    tg = ~tg;
    if (bsy != 0) bsy = bsy - 1;
  end
  always @(posedge we_n_i) if (!ce_n_i) begin
    nwr++;
    if (st == 1) begin
      cnt = d_i[7:0] + 8'h1;
      st = d_i > 127 ? 2'd0 : 2'd2;
      ab = d_i > 127;
      fst = 1;
    end else if (st == 2) begin
      if (fst) pg = a_i[AW-1:7];
      fst = 0;
      if (a_i[AW-1:7] != pg || a_i[AW-1:15] != sa) begin
        ab = 1;
        st = 0;
      end else begin
        mem[a_i[6:0]] = d_i;
        ld = d_i;
        cnt--;
        if (cnt == 0) st = 3;
      end
    end else if (st == 3) begin
      st = 0;
      if (d_i[7:0] == 8'h29 && a_i[AW-1:15] == sa && !abt_i) begin
        bsy = 2;
        fail = fl_i;
      end else ab = 1;
    end else if (x1) begin
      x1 = 0;
      if (d_i[7:0] == 8'h00) byp = 0;
    end else if (d_i[7:0] == 8'haa && a_i[11:0] == 12'h555) ul = 1;
    else if (d_i[7:0] == 8'h55 && ul == 1) ul = 2;
    else begin
      if (ul == 2 || byp || hv_i) case (d_i[7:0])
        8'h20: byp = 1;
        8'h25: begin
          st = 1;
          sa = a_i[AW-1:15];
        end
        8'h90: x1 = byp;
        default: ;
      endcase
      if (d_i[7:0] == 8'hf0) begin
        if (ul == 2) ab = 0;
        fail = 0;
      end
      ul = 0;
    end
  end
endmodule : fbp_flash_model
`default_nettype wire

// *** tb/fbp_host_tb.sv ***
/* Self-checking bench for fbp_host driving the flash model.
   Assumes the default FIFO depth of 32 words. */
`timescale 1ns/1ps
`default_nettype none
module fbp_host_tb;
  logic sys_clk_i = 0, rst_n_i = 0, cmd_valid_i = 0, sectors_unlocked_i = 0;
  logic wr_valid_i = 0, abt = 0, fl = 0;
  fbp_pkg::fbp_op_t cmd_op_i = fbp_pkg::OP_RESET;
  logic [21:0] cmd_addr_i = 22'h1a8000, flash_addr_o;
  logic [7:0]  cmd_count_i = 8'h0, status_o;
  logic [6:0]  wr_off_i = 7'h0;
  logic [15:0] wr_data_i = 16'h0, flash_dq_o;
  logic cmd_ready_o, done_o, fail_o, abort_o, refused_o, bypass_o, wr_ready_o;
  logic flash_dq_oe_o, flash_ce_n_o, flash_we_n_o, flash_oe_n_o, flash_accel_hv_o;
  int n_fail = 0, samples_checked = 0, cyc = 0, n;
  wire logic [15:0] mq;
  wire logic [15:0] dq_w = flash_dq_oe_o ? flash_dq_o : mq;
  fbp_host dut_u (.sys_clk_i, .rst_n_i, .cmd_valid_i, .cmd_op_i, .cmd_addr_i, .cmd_count_i,
    .sectors_unlocked_i, .cmd_ready_o, .done_o, .fail_o, .abort_o, .refused_o, .bypass_o,
    .status_o, .wr_valid_i, .wr_off_i, .wr_data_i, .wr_ready_o, .flash_addr_o, .flash_dq_o,
    .flash_dq_oe_o, .flash_dq_i(dq_w), .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o,
    .flash_accel_hv_o);
  fbp_flash_model mdl_u (.a_i(flash_addr_o), .d_i(dq_w), .ce_n_i(flash_ce_n_o),
    .we_n_i(flash_we_n_o), .oe_n_i(flash_oe_n_o), .hv_i(flash_accel_hv_o),
    .abt_i(abt), .fl_i(fl), .q_o(mq));
  task automatic print_verdict;
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Result code is {done, fail, abort, refused}.
  task automatic go(input fbp_pkg::fbp_op_t op, input logic [7:0] c, input logic [3:0] e);
    logic [3:0] r;
    cmd_op_i = op;
    cmd_count_i = c;
    cmd_valid_i = 1;
    while (!cmd_ready_o) @(posedge sys_clk_i) #1;
    @(posedge sys_clk_i) #1;
    cmd_valid_i = 0;
    r = {done_o, fail_o, abort_o, refused_o};
    for (int i = 0; i < 5000 && r == 0; i++) begin
      @(posedge sys_clk_i) #1;
      r = {done_o, fail_o, abort_o, refused_o};
    end
    while (!cmd_ready_o) @(posedge sys_clk_i) #1;
    chk({12'h0, r}, {12'h0, e});
  endtask : go
  // Valid stays up between pushes; the caller drops it.
  task automatic push(input logic [6:0] o, input logic [15:0] d);
    wr_off_i = o;
    wr_data_i = d;
    wr_valid_i = 1;
    while (!wr_ready_o) @(posedge sys_clk_i) #1;
    @(posedge sys_clk_i) #1;
  endtask : push
  task automatic t_accel;
    go(fbp_pkg::OP_ACCEL_ON, 8'h0, 4'h1);
    sectors_unlocked_i = 1;
    go(fbp_pkg::OP_ACCEL_ON, 8'h0, 4'h8);
    chk({14'h0, flash_accel_hv_o, bypass_o}, 16'h3);
    go(fbp_pkg::OP_BYP_EXIT, 8'h0, 4'h1);
    push(7'h11, 16'h0056);
    wr_valid_i = 0;
    abt = 1;
    n = mdl_u.nwr;
    go(fbp_pkg::OP_BUF_PROG, 8'h1, 4'h2);
    chk(16'(mdl_u.nwr - n), 16'd7);
    chk({15'h0, mdl_u.ab}, 16'h0);
    abt = 0;
    go(fbp_pkg::OP_ACCEL_OFF, 8'h0, 4'h8);
    chk({14'h0, flash_accel_hv_o, bypass_o}, 16'h0);
  endtask : t_accel
  task automatic t_byp;
    go(fbp_pkg::OP_BYP_ENTER, 8'h0, 4'h8);
    chk({14'h0, bypass_o, mdl_u.byp}, 16'h3);
    go(fbp_pkg::OP_BYP_ENTER, 8'h0, 4'h1);
    go(fbp_pkg::OP_BYP_EXIT, 8'h0, 4'h8);
    chk({14'h0, bypass_o, mdl_u.byp}, 16'h0);
    go(fbp_pkg::OP_BYP_EXIT, 8'h0, 4'h1);
  endtask : t_byp
  task automatic t_buf;
    go(fbp_pkg::OP_BYP_ENTER, 8'h0, 4'h8);
    for (int i = 0; i < 32; i++) push(i == 31 ? 7'h5 : 7'(i), 16'h0180 + 16'(i));
    wr_valid_i = 0;
    @(posedge sys_clk_i) #1;
    chk({15'h0, wr_ready_o}, 16'h0);
    n = mdl_u.nwr;
    go(fbp_pkg::OP_BUF_PROG, 8'h20, 4'h8);
    chk(16'(mdl_u.nwr - n), 16'd35);
    chk(mdl_u.mem[5], 16'h019f);
    chk({8'h0, status_o}, 16'h009f);
    go(fbp_pkg::OP_BYP_EXIT, 8'h0, 4'h8);
  endtask : t_buf
  task automatic t_err;
    go(fbp_pkg::OP_BUF_PROG, 8'h81, 4'h1);
    go(fbp_pkg::OP_BUF_PROG, 8'h00, 4'h1);
    push(7'h7f, 16'h0012);
    wr_valid_i = 0;
    abt = 1;
    n = mdl_u.nwr;
    go(fbp_pkg::OP_BUF_PROG, 8'h1, 4'h2);
    chk(16'(mdl_u.nwr - n), 16'd9);
    chk({15'h0, mdl_u.ab}, 16'h0);
    chk({13'h0, status_o[7], status_o[5], status_o[1]}, 16'h5);
    abt = 0;
    fl = 1;
    push(7'h03, 16'h0034);
    wr_valid_i = 0;
    go(fbp_pkg::OP_BUF_PROG, 8'h1, 4'h4);
    chk({15'h0, mdl_u.fail}, 16'h0);
    chk({15'h0, status_o[5]}, 16'h1);
    fl = 0;
    n = mdl_u.nwr;
    go(fbp_pkg::OP_ABORT_RESET, 8'h0, 4'h8);
    go(fbp_pkg::OP_RESET, 8'h0, 4'h8);
    chk(16'(mdl_u.nwr - n), 16'd4);
  endtask : t_err
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // A hang ends the run well after the expected several hundred cycles.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1 rst_n_i = 1;
    t_accel;
    t_byp;
    t_buf;
    t_err;
    print_verdict;
  end
endmodule : fbp_host_tb
`default_nettype wire
